// >>> power_and_output_control.sv
// Purpose: power-down and output formatting control with AHB-Lite registers
// Assumes: sync pins and power pin are asynchronous; pixel data and
//   field come from logic on hclk
// Notes: zero-wait slave; reads come from flops one cycle after address
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module power_and_output_control
  import pwr_out_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // asynchronous pins
  input wire logic power_down_pin,
  input wire logic horiz_sync_input_zero,
  input wire logic horiz_sync_input_one,
  input wire logic sog_input_zero,
  input wire logic sog_input_one,
  // core-side sources on hclk
  input wire logic [29:0] pixel_data,
  input wire logic odd_field,
  input wire logic vsync_in,
  input wire logic slicer_in,
  // control levels to the analog core and pads
  output logic high_bandwidth,
  output logic core_power_down,
  output logic [2:0] output_mode,
  output logic ddr_enable,
  output logic [1:0] drive_strength,
  output logic clock_invert,
  output logic [1:0] clock_select,
  // output pins
  output logic [19:0] primary_data,
  output logic primary_oe,
  output logic [9:0] secondary_data,
  output logic secondary_oe,
  output logic sync_slicer_output,
  output logic sync_slicer_oe,
  output logic field_output,
  output logic field_oe,
  output logic vertical_sync_output,
  output logic vertical_sync_oe
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] input_power_r;
  logic [7:0] output_format_r;
  logic [7:0] clock_tristate_r;
  logic [7:0] status_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [7:0] addr_idx;
  logic [7:0] rd_nxt;
  logic [7:0] wr_byte;
  logic take;
  logic fwd;
  logic [1:0] pin_sync_r;
  logic [NUM_SYNC-1:0] sync_pins;
  logic [NUM_SYNC-1:0] active;
  logic pin_active;
  logic pd_request;
  logic hiz_all;
  logic hiz_slicer;
  logic split_mode;
  logic [2:0] mode;

  // ---------------------------------------------------------------
  // bus address phase
  // ---------------------------------------------------------------
  // word index from byte address; hsize is taken as a whole word
  assign addr_idx = haddr[ADDR_LSB +: 8];
  assign take = hsel & htrans[1] & hready;
  assign wr_byte = hwdata[7:0];

  // read mux; a write still in its data phase is forwarded only to a
  // register it can land in, so status and holes never echo hwdata
  assign fwd = wr_pend_r && (wr_idx_r == addr_idx);
  always_comb
  begin
    unique case (addr_idx)
      IDX_INPUT_POWER: rd_nxt = fwd ? wr_byte : input_power_r;
      IDX_OUTPUT_FORMAT: rd_nxt = fwd ? wr_byte : output_format_r;
      IDX_CLOCK_TRISTATE: rd_nxt = fwd ? wr_byte : clock_tristate_r;
      IDX_ACTIVITY_STATUS: rd_nxt = status_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // capture write address for the following data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_r <= take & hwrite;
      if (take)
      begin
        wr_idx_r <= addr_idx;
      end
    end
  end

  // read data registered at the address phase, upper bits zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (clk_en && take && !hwrite)
    begin
      hrdata <= {24'h00_0000, rd_nxt};
    end
  end

  // never stalls and never errors; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // writes land in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      input_power_r <= RST_INPUT_POWER;
      output_format_r <= RST_OUTPUT_FORMAT;
      clock_tristate_r <= RST_CLOCK_TRISTATE;
    end
    else if (clk_en && wr_pend_r)
    begin
      unique case (wr_idx_r)
        IDX_INPUT_POWER: input_power_r <= wr_byte;
        IDX_OUTPUT_FORMAT: output_format_r <= wr_byte;
        IDX_CLOCK_TRISTATE: clock_tristate_r <= wr_byte;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // power pin: two flops; reset high, idle for the active-low default
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_sync_r <= 2'b11;
    end
    else if (clk_en)
    begin
      pin_sync_r <= {pin_sync_r[0], power_down_pin};
    end
  end

  assign sync_pins = {horiz_sync_input_zero, horiz_sync_input_one,
                      sog_input_zero, sog_input_one};

  // ---------------------------------------------------------------
  // activity detectors
  // ---------------------------------------------------------------
  // a level held either way times out; a toggle restarts the window
  generate
    for (genvar i = 0; i < NUM_SYNC; i++)
    begin : g_act
      logic [2:0] sh_r;
      logic [ACT_CNT_W-1:0] cnt_r;
      logic act_r;
      // sh_r[0] is read only by sh_r[1]; the edge is seen on 1 and 2
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sh_r <= 3'b000;
          cnt_r <= '0;
          act_r <= 1'b0;
        end
        else if (clk_en)
        begin
          sh_r <= {sh_r[1:0], sync_pins[i]};
          if (sh_r[2] != sh_r[1])
          begin
            cnt_r <= '0;
            act_r <= 1'b1;
          end
          else if (cnt_r == ACT_CNT_W'(ACT_WINDOW_CYC - 1))
          begin
            act_r <= 1'b0;
          end
          else
          begin
            cnt_r <= cnt_r + ACT_CNT_W'(1);
          end
        end
      end
      assign active[i] = act_r;
    end
  endgenerate

  // status image: detector results at their documented bit places
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_r <= 8'h00;
    end
    else if (clk_en)
    begin
      status_r <= 8'h00;
      status_r[STAT_HS0] <= active[3];
      status_r[STAT_HS1] <= active[2];
      status_r[STAT_SOG0] <= active[1];
      status_r[STAT_SOG1] <= active[0];
    end
  end

  // ---------------------------------------------------------------
  // power-down decision
  // ---------------------------------------------------------------
  // pin counts as active when its level equals the polarity bit
  assign pin_active =
    pin_sync_r[1] == input_power_r[BIT_PD_PIN_POL];

  // auto mode ignores the bit and pin; manual ignores activity
  assign pd_request = input_power_r[BIT_AUTO_PD]
    ? ~(status_r[STAT_HS0] | status_r[STAT_HS1]
      | status_r[STAT_SOG0] | status_r[STAT_SOG1])
    : (input_power_r[BIT_PD] | pin_active);

  // fast switch keeps the core running; outputs still float
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_power_down <= 1'b0;
    end
    else if (clk_en)
    begin
      core_power_down <= pd_request
                       & ~input_power_r[BIT_FAST_SWITCH];
    end
  end

  // ---------------------------------------------------------------
  // tri-state conditions
  // ---------------------------------------------------------------
  // powered down or fast-switched, every group except slicer floats
  assign hiz_all = clock_tristate_r[BIT_GLOBAL_HIZ] | pd_request;
  // slicer pin has its own control, plus optional power-down float
  assign hiz_slicer = clock_tristate_r[BIT_SLICER_HIZ]
                    | (pd_request & input_power_r[BIT_SLICER_PD_HIZ]);

  assign mode = output_format_r[MODE_HI:MODE_LO];
  // in 422 and ddr the blue lane becomes the secondary port
  assign split_mode = (mode == MODE_YCC422) | (mode == MODE_DDR444);

  // ---------------------------------------------------------------
  // pad control levels
  // ---------------------------------------------------------------
  // codes outside the table fall back to plain 444 timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_bandwidth <= RST_INPUT_POWER[BIT_BANDWIDTH];
      output_mode <= RST_OUTPUT_FORMAT[MODE_HI:MODE_LO];
      ddr_enable <= 1'b0;
      drive_strength <= RST_OUTPUT_FORMAT[DRIVE_HI:DRIVE_LO];
      clock_invert <= RST_OUTPUT_FORMAT[BIT_CLK_INV];
      clock_select <= RST_CLOCK_TRISTATE[CLKSEL_HI:CLKSEL_LO];
    end
    else if (clk_en)
    begin
      high_bandwidth <= input_power_r[BIT_BANDWIDTH];
      output_mode <= mode;
      ddr_enable <= (mode == MODE_DDR444);
      drive_strength <= output_format_r[DRIVE_HI:DRIVE_LO];
      clock_invert <= output_format_r[BIT_CLK_INV];
      clock_select <= clock_tristate_r[CLKSEL_HI:CLKSEL_LO];
    end
  end

  // ---------------------------------------------------------------
  // data outputs
  // ---------------------------------------------------------------
  // red/green on primary; blue is primary except in 422 and ddr, secondary there
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      primary_data <= 20'h0_0000;
      secondary_data <= 10'h000;
      primary_oe <= 1'b0;
      secondary_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      primary_data <= pixel_data[29:10];
      secondary_data <= pixel_data[9:0];
      primary_oe <= output_format_r[BIT_PRIM_EN] & ~hiz_all;
      if (split_mode)
      begin
        secondary_oe <= output_format_r[BIT_SEC_EN] & ~hiz_all;
      end
      else
      begin
        secondary_oe <= output_format_r[BIT_PRIM_EN] & ~hiz_all;
      end
    end
  end

  // ---------------------------------------------------------------
  // sync and field outputs
  // ---------------------------------------------------------------
  // polarity 0 gives high on odd fields, 1 gives high on even
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      field_output <= 1'b0;
      field_oe <= 1'b0;
      vertical_sync_output <= 1'b0;
      vertical_sync_oe <= 1'b0;
      sync_slicer_output <= 1'b0;
      sync_slicer_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      field_output <= odd_field ^ clock_tristate_r[BIT_FIELD_POL];
      field_oe <= ~hiz_all;
      vertical_sync_output <= vsync_in;
      vertical_sync_oe <= ~hiz_all;
      sync_slicer_output <= slicer_in;
      sync_slicer_oe <= ~hiz_slicer;
    end
  end

endmodule : power_and_output_control

`default_nettype wire

// >>> pwr_out_pkg.sv
// Purpose: constants for the power and output control register bank
// Assumes: 25 MHz bus clock, AHB-Lite word access
// Notes: register byte address is four times the register index
package pwr_out_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_INPUT_POWER = 8'h1E;
  localparam logic [7:0] IDX_OUTPUT_FORMAT = 8'h1F;
  localparam logic [7:0] IDX_CLOCK_TRISTATE = 8'h20;
  localparam logic [7:0] IDX_ACTIVITY_STATUS = 8'h24;
  localparam int ADDR_LSB = 2;

  // ---------------------------------------------------------------
  // input and power control fields
  // ---------------------------------------------------------------
  localparam int BIT_BANDWIDTH = 5;
  localparam int BIT_AUTO_PD = 4;
  localparam int BIT_PD = 3;
  localparam int BIT_PD_PIN_POL = 2;
  localparam int BIT_FAST_SWITCH = 1;
  localparam int BIT_SLICER_PD_HIZ = 0;
  localparam logic [7:0] RST_INPUT_POWER = 8'h20;

  // ---------------------------------------------------------------
  // output format fields
  // ---------------------------------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int BIT_PRIM_EN = 4;
  localparam int BIT_SEC_EN = 3;
  localparam int DRIVE_HI = 2;
  localparam int DRIVE_LO = 1;
  localparam int BIT_CLK_INV = 0;
  localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h94;
  localparam logic [2:0] MODE_RGB444 = 3'h4;
  localparam logic [2:0] MODE_YCC422 = 3'h5;
  localparam logic [2:0] MODE_DDR444 = 3'h6;

  // ---------------------------------------------------------------
  // output clock and tristate fields
  // ---------------------------------------------------------------
  localparam int CLKSEL_HI = 7;
  localparam int CLKSEL_LO = 6;
  localparam int BIT_GLOBAL_HIZ = 5;
  localparam int BIT_SLICER_HIZ = 4;
  localparam int BIT_FIELD_POL = 3;
  localparam logic [7:0] RST_CLOCK_TRISTATE = 8'h08;

  // ---------------------------------------------------------------
  // activity status bit positions and timing
  // ---------------------------------------------------------------
  localparam int NUM_SYNC = 4;
  localparam int STAT_HS0 = 7;
  localparam int STAT_HS1 = 6;
  localparam int STAT_SOG0 = 3;
  localparam int STAT_SOG1 = 2;
  localparam int CLK_KHZ = 25000;
  localparam int ACT_WINDOW_US = 100;
  localparam int ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_KHZ / 1000;
  localparam int ACT_CNT_W = 12;

endpackage : pwr_out_pkg

// >>> pwr_out_checker.sv
// Purpose: port-level checks for the power and output control bank
// Assumes: one hclk domain, clk_en held high by the bench
// Notes: attached by the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module pwr_out_checker
  import pwr_out_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [29:0] pixel_data,
  input wire logic vsync_in,
  input wire logic slicer_in,
  input wire logic core_power_down,
  input wire logic [2:0] output_mode,
  input wire logic ddr_enable,
  input wire logic [19:0] primary_data,
  input wire logic primary_oe,
  input wire logic [9:0] secondary_data,
  input wire logic secondary_oe,
  input wire logic sync_slicer_output,
  input wire logic sync_slicer_oe,
  input wire logic field_oe,
  input wire logic vertical_sync_output,
  input wire logic vertical_sync_oe
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // read taken, then its data phase
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_vs_on;
    vertical_sync_oe [*2];
  endsequence

  AST_BUS: assert property (s_rd |=> hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer wrong");
  // mode settled one cycle so a lagging ddr flag is tolerated
  AST_DDR: assert property ($stable(output_mode) |-> ddr_enable == (output_mode == MODE_DDR444))
    else $error("ddr flag disagrees with mode");
  AST_PD_OE: assert property (core_power_down && $past(core_power_down) |-> !primary_oe && !secondary_oe && !field_oe)
    else $error("outputs driven in power-down");
  AST_PRIM: assert property (primary_oe && $past(primary_oe) |-> primary_data == $past(pixel_data[29:10]))
    else $error("primary data wrong");
  AST_SEC: assert property (secondary_oe && $past(secondary_oe) |-> secondary_data == $past(pixel_data[9:0]))
    else $error("secondary data wrong");
  AST_SLICER: assert property (sync_slicer_oe && $past(sync_slicer_oe) |-> sync_slicer_output == $past(slicer_in))
    else $error("slicer output wrong");
  AST_VS: assert property (s_vs_on |-> vertical_sync_output == $past(vsync_in))
    else $error("vertical sync output wrong");
  AST_GROUP: assert property (field_oe == vertical_sync_oe)
    else $error("field and vsync enables differ");
  AST_PRIM_GRP: assert property (primary_oe |-> vertical_sync_oe)
    else $error("primary driven while group off");
endmodule : pwr_out_checker

bind power_and_output_control pwr_out_checker pwr_out_checker_inst (.*);
`default_nettype wire

// >>> display_sink.sv
// Purpose: display controller model capturing the pixel buses
// Assumes: capture on the hclk rising edge
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module display_sink
(
  input wire logic hclk,
  input wire logic [19:0] primary_data,
  input wire logic primary_oe,
  input wire logic [9:0] secondary_data,
  input wire logic secondary_oe,
  output logic [29:0] pixel_seen
);
  // released pins float, so a stale word is never shown as valid
  always_ff @(posedge hclk)
  begin
    pixel_seen[29:10] <= primary_oe ? primary_data : ~pixel_seen[29:10];
    pixel_seen[9:0] <= secondary_oe ? secondary_data : ~pixel_seen[9:0];
  end
endmodule : display_sink
`default_nettype wire

// >>> power_and_output_control_test.sv
// Purpose: self-checking bench for the power and output control bank
// Assumes: zero-wait slave, registers at four times their index
// Notes: expected values queued by the driver, compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module power_and_output_control_test
  import pwr_out_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, power_down_pin, odd_field;
  logic [1:0] htrans, drive_strength, clock_select;
  logic [2:0] hsize, output_mode;
  logic [31:0] haddr, hwdata, hrdata, got, e;
  logic [31:0] lf = 32'h9E88;
  logic [29:0] px;
  logic tog_all = 1'b0;
  logic [29:0] pixel_data = 30'h0;
  logic [29:0] pixel_seen;
  logic vsync_in = 1'b0;
  logic slicer_in = 1'b0;
  logic horiz_sync_input_zero = 1'b0;
  logic clk_en = 1'b1;
  logic horiz_sync_input_one = 1'b0;
  logic sog_input_zero = 1'b0;
  logic sog_input_one = 1'b0;
  logic high_bandwidth, core_power_down, ddr_enable, clock_invert, primary_oe, secondary_oe;
  logic sync_slicer_output, sync_slicer_oe, field_output, field_oe;
  logic vertical_sync_output, vertical_sync_oe, got_v, tog, pd;
  logic [19:0] primary_data;
  logic [9:0] secondary_data;
  logic [7:0] v;
  logic [31:0] q[$];
  int error_cnt, checked;

  assign hready = hreadyout;
  power_and_output_control power_and_output_control_inst (.*);
  display_sink display_sink_inst (.*);

  // ---------------------------------------------------------------
  // clock, random sources, monitor
  // ---------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // fresh pixel and sync values every cycle keep the data paths honest
  always @(posedge hclk)
  begin
    lf <= nxt(lf);
    pixel_data <= lf[29:0];
    vsync_in <= lf[30];
    slicer_in <= lf[31];
    if (tog)
      horiz_sync_input_zero <= ~horiz_sync_input_zero;
    if (tog_all)
    begin
      horiz_sync_input_one <= ~horiz_sync_input_one;
      sog_input_zero <= ~sog_input_zero;
      sog_input_one <= ~sog_input_one;
    end
  end

  // oldest note against each result shown
  always @(negedge hclk)
    if (got_v === 1'b1)
    begin
      e = q.pop_front();
      checked++;
      if (got !== e)
      begin
        error_cnt++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
      end
    end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic note(input logic [31:0] x, input logic [31:0] g);
    q.push_back(x);
    got <= g;
    got_v <= 1'b1;
    @(posedge hclk);
    got_v <= 1'b0;
    @(posedge hclk);
  endtask : note

  // one single transfer; address held until hready, then data phase
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
    rd = hrdata;
    if (n >= 100)
    begin
      error_cnt++;
      end_sim();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, {24'h0, d}, r);
    repeat (6) @(posedge hclk);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    note(x, r);
  endtask : rdc

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata, got, got_v, tog} = '0;
    {error_cnt, checked} = '0;
    power_down_pin = 1'b1;
    odd_field = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (7) @(posedge hclk);
    note(32'h190C, 32'({high_bandwidth, output_mode, drive_strength, clock_invert,
      clock_select, primary_oe, sync_slicer_oe, core_power_down, field_output}));
    rdc(IDX_INPUT_POWER, 32'h20);
    rdc(IDX_OUTPUT_FORMAT, 32'h94);
    rdc(IDX_CLOCK_TRISTATE, 32'h08);
    for (int i = 0; i < 12; i++)
    begin
      v = {3'(4 + i % 3), lf[4:0]};
      wr(IDX_OUTPUT_FORMAT, v);
      rdc(IDX_OUTPUT_FORMAT, {24'h0, v});
      note({v[7:5], v[7:5] == 3'h6, v[2:0], v[4], v[7:5] == 3'h4 ? v[4] : v[3]}, 32'({output_mode,
        ddr_enable, drive_strength, clock_invert, primary_oe, secondary_oe}));
    end
    wr(IDX_OUTPUT_FORMAT, 8'h94);
    // sink sees the pixel two edges after it reaches the core input
    px = pixel_data;
    repeat (2) @(posedge hclk);
    note({2'h0, px}, {2'h0, pixel_seen});
    for (int i = 0; i < 16; i++)
    begin
      v = lf[7:0] & 8'hEF;
      power_down_pin <= lf[8];
      wr(IDX_INPUT_POWER, v);
      pd = v[3] | (power_down_pin == v[2]);
      note({v[5], pd & ~v[1], ~pd, ~(pd & v[0])},
        32'({high_bandwidth, core_power_down, primary_oe, sync_slicer_oe}));
    end
    power_down_pin <= 1'b1;
    wr(IDX_INPUT_POWER, 8'h20);
    for (int i = 0; i < 8; i++)
    begin
      v = {lf[7:3], 3'h0};
      wr(IDX_CLOCK_TRISTATE, v);
      rdc(IDX_CLOCK_TRISTATE, {24'h0, v});
      note({v[7:6], ~v[5], ~v[4], ~v[5], ~v[5] & ~v[3]}, 32'({clock_select, primary_oe,
        sync_slicer_oe, field_oe, field_output & field_oe}));
    end
    wr(IDX_CLOCK_TRISTATE, 8'h08);
    wr(8'h21, 8'hFF);
    rdc(8'h21, 32'h0);
    rdc(IDX_ACTIVITY_STATUS, 32'h0);
    // auto mode with an active-level pin and bit 3 set: both ignored
    power_down_pin <= 1'b0;
    tog <= 1'b1;
    wr(IDX_INPUT_POWER, 8'h38);
    rdc(IDX_ACTIVITY_STATUS, 32'h80);
    note(32'h1, 32'({core_power_down, primary_oe}));
    // every sync pin toggling lands on its own status bit
    tog_all <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(IDX_ACTIVITY_STATUS, 32'hCC);
    tog <= 1'b0;
    tog_all <= 1'b0;
    repeat (2600) @(posedge hclk);
    rdc(IDX_ACTIVITY_STATUS, 32'h0);
    note(32'h2, 32'({core_power_down, primary_oe}));
    end_sim();
  end
endmodule : power_and_output_control_test
`default_nettype wire
